// ---- shared/ejc_pkg.sv ----
// constants, types and helpers shared by the ejector mode controller
package ejc_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned HOLD_TIME_MS = 3000;
    localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned FLASH_TIME_MS = 250;
    localparam int unsigned FLASH_CYCLES = FLASH_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W = 27;

    localparam int unsigned PAR_W = 16;
    localparam int unsigned PAR_N = 6;
    localparam logic [15:0] IDX_VAC_SP = 16'h0064;
    localparam logic [15:0] IDX_VAC_HYST = 16'h0065;
    localparam logic [15:0] IDX_PART_LVL = 16'h0066;
    localparam logic [15:0] IDX_PART_HYST = 16'h0067;
    localparam logic [15:0] IDX_PRESS_LVL = 16'h0068;
    localparam logic [15:0] IDX_PRESS_HYST = 16'h0069;
    localparam logic [2:0] SLOT_VAC_SP = 3'h0;
    localparam logic [2:0] SLOT_VAC_HYST = 3'h1;
    localparam logic [2:0] SLOT_PART_LVL = 3'h2;
    localparam logic [2:0] SLOT_PART_HYST = 3'h3;
    localparam logic [2:0] SLOT_PRESS_LVL = 3'h4;
    localparam logic [2:0] SLOT_PRESS_HYST = 3'h5;
    localparam logic [2:0] SLOT_NONE = 3'h7;

    // values after reset, mbar for vacuum, 0.1 bar for pressure
    localparam logic [15:0] RST_VAC_SP = 16'h02EE;
    localparam logic [15:0] RST_VAC_HYST = 16'h0096;
    localparam logic [15:0] RST_PART_LVL = 16'h0226;
    localparam logic [15:0] RST_PART_HYST = 16'h0032;
    localparam logic [15:0] RST_PRESS_LVL = 16'h0028;
    localparam logic [15:0] RST_PRESS_HYST = 16'h0005;

    localparam logic [15:0] RELEASE_MBAR = 16'h0014;
    localparam logic [15:0] UNDERVOLT_MV = 16'h4B00;
    localparam logic [15:0] SENSOR_FULL_SCALE = 16'h03E8;
    localparam logic [15:0] ZERO_LIMIT = 16'(32'(SENSOR_FULL_SCALE) * 3 / 100);

    typedef enum logic [1:0] {MODE_AUTO, MODE_MANUAL, MODE_SETTING} ejc_mode_e;
    typedef enum logic [1:0] {DISP_NONE, DISP_MANUAL, DISP_LOCKED, DISP_UNDERVOLT} ejc_disp_e;

    // output process byte bits 2..0
    typedef struct packed {
        logic setting;
        logic blowOff;
        logic suction;
    } ejc_pdo_s;

    typedef struct packed {
        logic entryA;
        logic entryB;
        logic suction;
        logic blowOff;
        logic exitKey;
    } ejc_keys_s;

    typedef struct packed {
        logic suctionLed;
        logic blowLed;
        logic setpointLed;
        logic partLed;
    } ejc_leds_s;

    // switch-off point below an on level, floored at zero
    function automatic logic [15:0] ejc_off_level(input logic [15:0] onLvl,
                                                  input logic [15:0] hyst);
        ejc_off_level = (hyst > onLvl) ? 16'h0000 : onLvl - hyst;
    endfunction

    // parameter index to storage slot
    function automatic logic [2:0] ejc_slot(input logic [15:0] idx);
        if (idx >= IDX_VAC_SP && idx <= IDX_PRESS_HYST) begin
            ejc_slot = 3'(idx - IDX_VAC_SP);
        end else begin
            ejc_slot = SLOT_NONE;
        end
    endfunction

endpackage

// ---- hw/ejc_param_mem.sv ----
// six-word limit value store with registered read data
`timescale 1ns/1ps
`default_nettype none
module ejc_param_mem
    import ejc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wrEn,
    input wire logic [2:0] wrSlot,
    input wire logic [15:0] wrData,
    input wire logic [2:0] rdSlot,
    output logic [15:0] rdData,
    output logic [PAR_N-1:0][15:0] words
);
    logic [PAR_N-1:0][15:0] mem_reg;

    assign words = mem_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_reg <= {RST_PRESS_HYST, RST_PRESS_LVL, RST_PART_HYST,
                        RST_PART_LVL, RST_VAC_HYST, RST_VAC_SP};
        end else if (wrEn && wrSlot < 3'(PAR_N)) begin
            mem_reg[wrSlot] <= wrData;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= 16'h0000;
        end else begin
            rdData <= (rdSlot < 3'(PAR_N)) ? mem_reg[rdSlot] : 16'h0000;
        end
    end
endmodule
`default_nettype wire

// ---- hw/ejc_hyst_cmp.sv ----
// level comparator with switch-on point and hysteresis
`timescale 1ns/1ps
`default_nettype none
module ejc_hyst_cmp
    import ejc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] level,
    input wire logic [15:0] onLevel,
    input wire logic [15:0] hyst,
    output logic active
);
    wire logic reachOn = level >= onLevel;
    wire logic fallOff = level < ejc_off_level(onLevel, hyst);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            active <= 1'b0;
        end else if (reachOn) begin
            active <= 1'b1;
        end else if (fallOff) begin
            active <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- hw/ejc_mode_ctrl.sv ----
// ejector operating mode, valve, LED and limit value control
`timescale 1ns/1ps
`default_nettype none
module ejc_mode_ctrl
    import ejc_pkg::*;
#(
    parameter int unsigned HOLD_COUNT = HOLD_CYCLES,
    parameter int unsigned FLASH_COUNT = FLASH_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire ejc_pdo_s outputProcessByte,
    input wire logic ioLinkMode,
    input wire logic manualLocked,
    input wire ejc_keys_s keys,
    input wire logic controlEnable,
    input wire logic [15:0] vacuumLevel,
    input wire logic [15:0] pressureLevel,
    input wire logic [15:0] supplyMillivolt,
    input wire logic paramWrite,
    input wire logic paramRead,
    input wire logic [15:0] paramIndex,
    input wire logic [15:0] paramData,
    input wire logic zeroStartLink,
    input wire logic zeroStartMenu,
    input wire logic zeroPressure,
    input wire logic menuLocked,
    input wire logic pinValid,
    input wire logic signed [15:0] measuredOffset,
    output logic suctionValve,
    output logic blowValve,
    output ejc_leds_s leds,
    output ejc_disp_e displayCode,
    output ejc_mode_e mode,
    output logic valveProtect,
    output logic vacuumSetpointReached,
    output logic partPresent,
    output logic partReleased,
    output logic pressureReached,
    output logic underVoltage,
    output logic paramAck,
    output logic paramReject,
    output logic [15:0] paramReadData,
    output logic paramReadValid,
    output logic zeroDone,
    output logic zeroReject,
    output logic signed [15:0] vacuumZeroOffset,
    output logic signed [15:0] pressureZeroOffset
);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_COUNT - 1);
    localparam logic [CNT_W-1:0] FLASH_LAST = CNT_W'(FLASH_COUNT - 1);

    // ***
    // parameter store and comparators
    // ***
    logic [PAR_N-1:0][15:0] words;
    logic [15:0] memRdData;
    logic ctrlActive;
    logic partActive;
    logic pressActive;

    wire ejc_mode_e modeNow = mode;
    wire logic inAuto = modeNow == MODE_AUTO;
    wire logic [2:0] accessSlot = ejc_slot(paramIndex);
    wire logic slotValid = accessSlot != SLOT_NONE;
    wire logic writeOk = paramWrite && slotValid && inAuto;

    ejc_param_mem u_mem (
        .clk(clk),
        .rst_b(rst_b),
        .wrEn(writeOk),
        .wrSlot(accessSlot),
        .wrData(paramData),
        .rdSlot(accessSlot),
        .rdData(memRdData),
        .words(words)
    );

    // control switches on at the setpoint, off below setpoint minus hysteresis
    ejc_hyst_cmp u_ctrl (
        .clk(clk),
        .rst_b(rst_b),
        .level(vacuumLevel),
        .onLevel(words[SLOT_VAC_SP]),
        .hyst(words[SLOT_VAC_HYST]),
        .active(ctrlActive)
    );

    ejc_hyst_cmp u_part (
        .clk(clk),
        .rst_b(rst_b),
        .level(vacuumLevel),
        .onLevel(words[SLOT_PART_LVL]),
        .hyst(words[SLOT_PART_HYST]),
        .active(partActive)
    );

    ejc_hyst_cmp u_press (
        .clk(clk),
        .rst_b(rst_b),
        .level(pressureLevel),
        .onLevel(words[SLOT_PRESS_LVL]),
        .hyst(words[SLOT_PRESS_HYST]),
        .active(pressActive)
    );

    // ***
    // input edges
    // ***
    ejc_pdo_s pdoPrev_reg;
    ejc_keys_s keysPrev_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pdoPrev_reg <= '0;
            keysPrev_reg <= '0;
        end else begin
            pdoPrev_reg <= outputProcessByte;
            keysPrev_reg <= keys;
        end
    end

    wire ejc_keys_s keyPress = keys & ~keysPrev_reg;
    wire logic pdoChange = outputProcessByte != pdoPrev_reg;
    wire logic cmdChange = outputProcessByte.suction != pdoPrev_reg.suction
                           || outputProcessByte.blowOff != pdoPrev_reg.blowOff;
    wire logic settingRise = outputProcessByte.setting && !pdoPrev_reg.setting;
    wire logic suctionOnCmd = outputProcessByte.suction && !pdoPrev_reg.suction;

    // ***
    // two-button hold timer
    // ***
    logic [CNT_W-1:0] holdCnt_reg;
    logic [CNT_W-1:0] holdCnt_next;
    logic holdDone_reg;

    wire logic bothHeld = keys.entryA && keys.entryB;
    wire logic holdExpired = bothHeld && holdCnt_reg == HOLD_LAST && !holdDone_reg;

    // count restarts when either key lets go early
    assign holdCnt_next = !bothHeld ? '0 :
                          (holdCnt_reg == HOLD_LAST) ? holdCnt_reg :
                          holdCnt_reg + CNT_W'(1);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            holdCnt_reg <= '0;
            holdDone_reg <= 1'b0;
        end else begin
            holdCnt_reg <= holdCnt_next;
            holdDone_reg <= bothHeld && (holdDone_reg || holdExpired);
        end
    end

    // ***
    // mode machine
    // ***
    ejc_mode_e mode_next;
    logic lockedShown_reg;
    logic lockedShown_next;

    wire logic manualEnter = holdExpired && !manualLocked;
    wire logic manualRefuse = holdExpired && manualLocked;
    wire logic manualLeave = keyPress.exitKey || pdoChange;
    wire logic settingLeave = !outputProcessByte.setting || cmdChange
                              || !ioLinkMode;

    always_comb begin
        mode_next = modeNow;
        case (modeNow)
            MODE_AUTO: begin
                if (manualEnter) begin
                    mode_next = MODE_MANUAL;
                end else if (settingRise && ioLinkMode && !cmdChange) begin
                    mode_next = MODE_SETTING;
                end
            end
            MODE_MANUAL: begin
                if (manualLeave) begin
                    mode_next = MODE_AUTO;
                end
            end
            MODE_SETTING: begin
                if (settingLeave) begin
                    mode_next = MODE_AUTO;
                end
            end
            default: begin
                mode_next = MODE_AUTO;
            end
        endcase
    end

    // locked code stays until the lock is lifted or manual is reached
    assign lockedShown_next = manualRefuse || (lockedShown_reg && manualLocked
                              && mode_next != MODE_MANUAL);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode <= MODE_AUTO;
            lockedShown_reg <= 1'b0;
        end else begin
            mode <= mode_next;
            lockedShown_reg <= lockedShown_next;
        end
    end

    // ***
    // manual suction and blow-off
    // ***
    logic manSuction_reg;
    logic manSuction_next;

    wire logic inManualNext = mode_next == MODE_MANUAL;
    wire logic inManual = modeNow == MODE_MANUAL;

    always_comb begin
        manSuction_next = manSuction_reg;
        if (!inManual || !inManualNext) begin
            manSuction_next = 1'b0;
        end else if (keyPress.suction) begin
            manSuction_next = !manSuction_reg;
        end else if (keyPress.blowOff) begin
            manSuction_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            manSuction_reg <= 1'b0;
        end else begin
            manSuction_reg <= manSuction_next;
        end
    end

    // ***
    // valve drive
    // ***
    // limit values gate suction in every mode when control is enabled
    wire logic limitGate = !controlEnable || !ctrlActive;
    wire logic manBlowNext = inManualNext && keys.blowOff;
    logic suctionNext;
    logic blowNext;

    always_comb begin
        case (mode_next)
            MODE_MANUAL: begin
                blowNext = manBlowNext;
                suctionNext = manSuction_next && !manBlowNext && limitGate;
            end
            MODE_SETTING: begin
                // control held active regardless of controlEnable
                blowNext = outputProcessByte.blowOff;
                suctionNext = outputProcessByte.suction && !blowNext
                              && !ctrlActive;
            end
            default: begin
                blowNext = outputProcessByte.blowOff;
                suctionNext = outputProcessByte.suction && !blowNext && limitGate;
            end
        endcase
    end

    // ***
    // part released latch and undervoltage
    // ***
    logic releaseArmed_reg;
    wire logic belowRelease = vacuumLevel < RELEASE_MBAR;
    wire logic releaseSet = releaseArmed_reg && belowRelease;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            releaseArmed_reg <= 1'b0;
            partReleased <= 1'b0;
        end else begin
            if (partActive) begin
                releaseArmed_reg <= 1'b1;
            end else if (releaseSet) begin
                releaseArmed_reg <= 1'b0;
            end
            // a new event wins over the clear
            if (releaseSet) begin
                partReleased <= 1'b1;
            end else if (suctionOnCmd) begin
                partReleased <= 1'b0;
            end
        end
    end

    wire logic lowSupply = supplyMillivolt < UNDERVOLT_MV;

    // ***
    // LED flash and display
    // ***
    logic [CNT_W-1:0] flashCnt_reg;
    logic flashPhase_reg;
    wire logic flashMode = mode_next != MODE_AUTO;
    wire logic flashWrap = flashCnt_reg == FLASH_LAST;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flashCnt_reg <= '0;
            flashPhase_reg <= 1'b0;
        end else if (!flashMode) begin
            flashCnt_reg <= '0;
            flashPhase_reg <= 1'b0;
        end else begin
            flashCnt_reg <= flashWrap ? '0 : flashCnt_reg + CNT_W'(1);
            flashPhase_reg <= flashPhase_reg ^ flashWrap;
        end
    end

    // both indicators blink together outside automatic mode
    wire logic setLedNext = flashMode ? !flashPhase_reg : ctrlActive;
    wire logic partLedNext = flashMode ? !flashPhase_reg : partActive;
    wire ejc_disp_e dispNext = lockedShown_next ? DISP_LOCKED :
                               inManualNext ? DISP_MANUAL :
                               lowSupply ? DISP_UNDERVOLT : DISP_NONE;

    // ***
    // zero-point calibration
    // ***
    wire logic zeroReq = zeroStartLink
                         || (zeroStartMenu && (!menuLocked || pinValid));
    wire logic [15:0] offsetMag = measuredOffset[15] ? 16'(-measuredOffset)
                                                     : 16'(measuredOffset);
    wire logic zeroInRange = offsetMag <= ZERO_LIMIT;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            zeroDone <= 1'b0;
            zeroReject <= 1'b0;
            vacuumZeroOffset <= 16'sh0000;
            pressureZeroOffset <= 16'sh0000;
        end else begin
            zeroDone <= zeroReq && zeroInRange;
            zeroReject <= (zeroReq && !zeroInRange)
                          || (zeroStartMenu && menuLocked && !pinValid);
            if (zeroReq && zeroInRange && !zeroPressure) begin
                vacuumZeroOffset <= measuredOffset;
            end
            if (zeroReq && zeroInRange && zeroPressure) begin
                pressureZeroOffset <= measuredOffset;
            end
        end
    end

    // ***
    // registered outputs
    // ***
    assign paramReadData = memRdData;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            suctionValve <= 1'b0;
            blowValve <= 1'b0;
            leds <= '0;
            displayCode <= DISP_NONE;
            valveProtect <= 1'b1;
            vacuumSetpointReached <= 1'b0;
            partPresent <= 1'b0;
            pressureReached <= 1'b0;
            underVoltage <= 1'b0;
            paramAck <= 1'b0;
            paramReject <= 1'b0;
            paramReadValid <= 1'b0;
        end else begin
            suctionValve <= suctionNext;
            blowValve <= blowNext;
            leds <= '{suctionLed: suctionNext, blowLed: blowNext,
                      setpointLed: setLedNext, partLed: partLedNext};
            displayCode <= dispNext;
            valveProtect <= mode_next == MODE_AUTO;
            vacuumSetpointReached <= ctrlActive;
            partPresent <= partActive;
            pressureReached <= pressActive;
            underVoltage <= lowSupply;
            paramAck <= writeOk;
            paramReject <= paramWrite && !writeOk;
            paramReadValid <= paramRead && slotValid;
        end
    end
endmodule
`default_nettype wire

// ---- tb/ejc_mode_ctrl_assertions.sv ----
// port-level checks of the ejector mode controller
`timescale 1ns/1ps
`default_nettype none
module ejc_mode_ctrl_assertions
    import ejc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire ejc_pdo_s outputProcessByte,
    input wire logic ioLinkMode,
    input wire ejc_keys_s keys,
    input wire logic [15:0] supplyMillivolt,
    input wire logic paramWrite,
    input wire logic [15:0] paramIndex,
    input wire logic zeroStartLink,
    input wire logic signed [15:0] measuredOffset,
    input wire logic blowValve,
    input wire ejc_mode_e mode,
    input wire logic valveProtect,
    input wire logic partReleased,
    input wire logic underVoltage,
    input wire logic paramAck,
    input wire logic paramReject,
    input wire logic zeroReject
);
    // ***
    // checks
    // ***
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_setReq;
        mode == MODE_AUTO && ioLinkMode && $rose(outputProcessByte.setting)
            && $stable(outputProcessByte[1:0]);
    endsequence
    sequence s_goodWrite;
        paramWrite && mode == MODE_AUTO && paramIndex >= IDX_VAC_SP && paramIndex <= IDX_PRESS_HYST;
    endsequence
    a_write_in_auto:
        assert property (s_goodWrite |=> paramAck && !paramReject) else $error("write not acked");
    a_write_outside_auto:
        assert property (paramWrite && mode != MODE_AUTO |=> paramReject && !paramAck)
            else $error("write not refused");
    a_protect_only_auto:
        assert property (mode != MODE_AUTO |-> !valveProtect) else $error("protection on");
    a_manual_exit_pdo:
        assert property (mode == MODE_MANUAL && $changed(outputProcessByte) |=> mode == MODE_AUTO)
            else $error("manual kept");
    a_manual_blow_key:
        assert property (mode == MODE_MANUAL ##1 mode == MODE_MANUAL |-> blowValve == $past(keys.blowOff))
            else $error("blow valve not following key");
    a_released_held:
        assert property (partReleased && !$rose(outputProcessByte.suction) |=> partReleased)
            else $error("released dropped early");
    a_undervolt_flag:
        assert property (1'b1 |=> underVoltage == $past(supplyMillivolt < UNDERVOLT_MV))
            else $error("undervoltage flag wrong");
    a_zero_out_range:
        assert property (zeroStartLink && (measuredOffset > 16'sh001E || measuredOffset < -16'sh001E)
            |=> zeroReject) else $error("zero not refused");
    a_setting_entry:
        assert property (s_setReq |=> mode == MODE_SETTING) else $error("no setting mode");
endmodule
bind ejc_mode_ctrl ejc_mode_ctrl_assertions u_ejc_mode_ctrl_assertions (.*);
`default_nettype wire

// ---- tb/ejc_link_master.sv ----
// behavioural controller side: process data byte and parameter access
`timescale 1ns/1ps
`default_nettype none
module ejc_link_master
    import ejc_pkg::*;
(
    input wire logic clk,
    input wire logic paramAck,
    input wire logic paramReject,
    input wire logic [15:0] paramReadData,
    output ejc_pdo_s outputProcessByte,
    output logic ioLinkMode,
    output logic manualLocked,
    output logic paramWrite,
    output logic paramRead,
    output logic [15:0] paramIndex,
    output logic [15:0] paramData
);
    // ***
    // request driver
    // ***
    initial begin
        {outputProcessByte, manualLocked} = 4'h0;
        ioLinkMode = 1'b1;
        {paramWrite, paramRead} = 2'h0;
        {paramIndex, paramData} = 32'h0000_0000;
    end
    // one request held for a single edge, lines scrambled once released
    task automatic acc(input logic wr, input logic [15:0] idx, input logic [15:0] dat,
                       output logic ack, output logic rej, output logic [15:0] rd);
        paramWrite = wr;
        paramRead = !wr;
        paramIndex = idx;
        paramData = dat;
        @(posedge clk);
        #1;
        ack = paramAck;
        rej = paramReject;
        rd = paramReadData;
        paramWrite = 1'b0;
        paramRead = 1'b0;
        paramIndex = ~idx;
        paramData = ~dat;
        @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench of the ejector mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ejc_pkg::*;
    logic clk, rst_b, zeroStartLink, zeroStartMenu, menuLocked, pinValid, ack, rej, l;
    logic suctionValve, blowValve, partReleased, underVoltage, zeroDone, zeroReject;
    logic [15:0] vacuumLevel, supplyMillivolt, measuredOffset, rd;
    logic signed [15:0] vacuumZeroOffset;
    ejc_keys_s keys;
    ejc_leds_s leds;
    ejc_disp_e displayCode;
    ejc_mode_e mode;
    ejc_pdo_s outputProcessByte;
    wire logic ioLinkMode, manualLocked, paramWrite, paramRead, paramAck, paramReject;
    wire logic [15:0] paramIndex, paramData, paramReadData;
    logic [15:0] rv [6] = '{RST_VAC_SP, RST_VAC_HYST, RST_PART_LVL, RST_PART_HYST,
                           RST_PRESS_LVL, RST_PRESS_HYST};
    int failures, compares, n;
    ejc_link_master u_ejc_link_master (.clk(clk), .paramAck(paramAck), .paramReject(paramReject),
        .paramReadData(paramReadData), .outputProcessByte(outputProcessByte),
        .ioLinkMode(ioLinkMode), .manualLocked(manualLocked), .paramWrite(paramWrite),
        .paramRead(paramRead), .paramIndex(paramIndex), .paramData(paramData));
    ejc_mode_ctrl #(.HOLD_COUNT(20), .FLASH_COUNT(4)) u_ejc_mode_ctrl (.clk(clk), .rst_b(rst_b),
        .outputProcessByte(outputProcessByte), .ioLinkMode(ioLinkMode),
        .manualLocked(manualLocked), .keys(keys), .controlEnable(1'b1),
        .vacuumLevel(vacuumLevel), .pressureLevel(16'h0000), .supplyMillivolt(supplyMillivolt),
        .paramWrite(paramWrite), .paramRead(paramRead), .paramIndex(paramIndex),
        .paramData(paramData), .zeroStartLink(zeroStartLink), .zeroStartMenu(zeroStartMenu),
        .zeroPressure(1'b0), .menuLocked(menuLocked), .pinValid(pinValid),
        .measuredOffset(measuredOffset), .suctionValve(suctionValve), .blowValve(blowValve),
        .leds(leds), .displayCode(displayCode), .mode(mode), .valveProtect(),
        .vacuumSetpointReached(), .partPresent(), .partReleased(partReleased),
        .pressureReached(), .underVoltage(underVoltage), .paramAck(paramAck),
        .paramReject(paramReject), .paramReadData(paramReadData), .paramReadValid(),
        .zeroDone(zeroDone), .zeroReject(zeroReject), .vacuumZeroOffset(vacuumZeroOffset),
        .pressureZeroOffset());
    // ***
    // helpers
    // ***
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic pa(input logic wr, input logic [15:0] idx, input logic [15:0] dat);
        u_ejc_link_master.acc(wr, idx, dat, ack, rej, rd);
    endtask
    task automatic pd(input logic [2:0] v, input int k);
        u_ejc_link_master.outputProcessByte = v;
        cyc(k);
    endtask
    task automatic sv(input logic [15:0] v, input logic e);
        vacuumLevel = v;
        cyc(3);
        chk(suctionValve, e);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tap(input logic [4:0] k);
        keys = k;
        cyc(1);
        keys = 5'h00;
        cyc(2);
    endtask
    task automatic zero(input logic [15:0] off, input logic menu, input logic lk, input logic pin,
                        input logic exp);
        measuredOffset = off;
        zeroStartMenu = menu;
        zeroStartLink = !menu;
        menuLocked = lk;
        pinValid = pin;
        cyc(1);
        zeroStartMenu = 1'b0;
        zeroStartLink = 1'b0;
        chk({zeroDone, zeroReject}, {exp, !exp});
        cyc(1);
    endtask
    task automatic give_verdict;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ***
    // sequence of tests
    // ***
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        give_verdict();
    end
    initial begin
        {rst_b, zeroStartLink, zeroStartMenu, menuLocked, pinValid} = 5'h00;
        keys = 5'h00;
        vacuumLevel = 16'h0000;
        supplyMillivolt = 16'h5DC0;
        measuredOffset = 16'h0000;
        cyc(10);
        rst_b = 1'b1;
        cyc(1);
        chk(mode, MODE_AUTO);
        foreach (rv[i]) begin
            pa(1'b0, 16'(IDX_VAC_SP + i), 16'h0000);
            chk(rd, rv[i]);
        end
        pa(1'b1, IDX_VAC_HYST, 16'h00C8);
        chk(ack, 1'b1);
        pa(1'b1, 16'h006A, 16'h0001);
        chk(rej, 1'b1);
        pd(3'h1, 3);
        chk(suctionValve, 1'b1);
        sv(16'h02EE, 1'b0);
        sv(16'h0230, 1'b0);
        sv(16'h0225, 1'b1);
        vacuumLevel = 16'h0013;
        cyc(3);
        chk(partReleased, 1'b1);
        vacuumLevel = 16'h0064;
        pd(3'h0, 3);
        chk(partReleased, 1'b1);
        pd(3'h1, 3);
        chk(partReleased, 1'b0);
        supplyMillivolt = 16'h4AFF;
        cyc(2);
        chk(underVoltage, 1'b1);
        supplyMillivolt = 16'h4B00;
        cyc(2);
        chk(underVoltage, 1'b0);
        zero(16'h001E, 1'b0, 1'b0, 1'b0, 1'b1);
        chk(vacuumZeroOffset, 16'h001E);
        zero(16'hFFE1, 1'b0, 1'b0, 1'b0, 1'b0);
        zero(16'h0000, 1'b1, 1'b1, 1'b0, 1'b0);
        zero(16'hFFE2, 1'b1, 1'b1, 1'b1, 1'b1);
        u_ejc_link_master.manualLocked = 1'b1;
        keys = 5'h18;
        cyc(25);
        chk({mode, displayCode}, {MODE_AUTO, DISP_LOCKED});
        keys = 5'h00;
        u_ejc_link_master.manualLocked = 1'b0;
        cyc(1);
        keys = 5'h18;
        cyc(15);
        keys = 5'h00;
        cyc(1);
        keys = 5'h18;
        cyc(15);
        chk(mode, MODE_AUTO);
        cyc(8);
        chk({mode, displayCode}, {MODE_MANUAL, DISP_MANUAL});
        keys = 5'h00;
        n = 0;
        repeat (12) begin
            l = leds.setpointLed;
            cyc(1);
            n += int'(l !== leds.setpointLed);
        end
        chk(n >= 2 && n <= 3, 1'b1);
        pa(1'b1, IDX_VAC_SP, 16'h0100);
        chk({ack, rej}, 2'b01);
        tap(5'h04);
        chk({suctionValve, leds.suctionLed}, 2'b11);
        tap(5'h04);
        chk(suctionValve, 1'b0);
        tap(5'h04);
        keys = 5'h02;
        cyc(2);
        chk({suctionValve, blowValve, leds.blowLed}, 3'b011);
        keys = 5'h00;
        cyc(2);
        chk({suctionValve, blowValve}, 2'b00);
        tap(5'h01);
        chk(mode, MODE_AUTO);
        keys = 5'h18;
        cyc(22);
        keys = 5'h00;
        pd(3'h0, 2);
        chk(mode, MODE_AUTO);
        pd(3'h4, 2);
        chk(mode, MODE_SETTING);
        pd(3'h5, 2);
        chk(mode, MODE_AUTO);
        u_ejc_link_master.ioLinkMode = 1'b0;
        pd(3'h0, 2);
        pd(3'h4, 2);
        chk(mode, MODE_AUTO);
        give_verdict();
    end
endmodule
`default_nettype wire
